/* File: src/ufs_frame_slave_port.sv */
// Frame receiver and responder for the multi-drop command link
module ufs_frame_slave_port
    import ufs_pkg::*;
#(
    parameter int unsigned P_GAP_CYC0 = GAP_CYC0,
    parameter int unsigned P_GAP_CYC1 = GAP_CYC1,
    parameter int unsigned P_GAP_CYC2 = GAP_CYC2,
    parameter int unsigned P_GAP_CYC3 = GAP_CYC3
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_rx,
    output logic o_tx,
    input wire logic i_identity_pin_high,
    input wire logic i_identity_pin_mid,
    input wire logic i_identity_pin_low,
    input wire logic i_nv_valid,
    input wire logic i_nv_address_source_select,
    input wire logic [3:0] i_nv_slave_identity,
    input wire logic [1:0] i_frame_gap_limit_cfg,
    input wire logic [7:0] i_primary_fault_summary,
    output logic [7:0] o_reg_addr,
    output logic [7:0] o_reg_wdata,
    output logic o_reg_wr,
    output logic o_reg_rd,
    input wire logic [7:0] i_reg_rdata,
    output logic o_wdt_clear,
    output logic [3:0] o_slave_id,
    output logic o_pins_as_pwm
);

    localparam logic [PER_W-1:0] PER_LO = PER_W'(SPAN_MIN >> SYNC_SHIFT);
    localparam logic [PER_W-1:0] PER_HI = PER_W'(SPAN_MAX >> SYNC_SHIFT);
    // Input synchronisers
    logic rx_q1_r, rx_q2_r, rx_d3_r;
    logic [2:0] pin_q1_r, pin_q2_r;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rx_q1_r <= 1'b1;
            rx_q2_r <= 1'b1;
            rx_d3_r <= 1'b1;
            pin_q1_r <= 3'h0;
            pin_q2_r <= 3'h0;
        end else begin
            rx_q1_r <= i_rx;
            rx_q2_r <= rx_q1_r;
            rx_d3_r <= rx_q2_r;
            pin_q1_r <= {i_identity_pin_high, i_identity_pin_mid, i_identity_pin_low};
            pin_q2_r <= pin_q1_r;
        end
    end

    logic line_fall, line_edge;
    assign line_fall = rx_d3_r & ~rx_q2_r;
    assign line_edge = rx_d3_r ^ rx_q2_r;

    // Frame state declarations
    ufs_state_t state_r, state_nxt;
    logic [PER_W-1:0] bit_per_r, bit_per_nxt, tx_cnt_r, tx_cnt_nxt;
    logic [SPAN_W-1:0] span_r, span_nxt;
    logic [2:0] falls_r, falls_nxt;
    logic [GAP_W-1:0] gap_r, gap_nxt, gap_lim;
    logic [7:0] tsel_r, tsel_nxt, ptr_r, ptr_nxt, crc_r, crc_nxt, crc_upd;
    logic [7:0] reg_addr_nxt, reg_wdata_nxt;
    logic [2:0] idx_r, idx_nxt, last_idx;
    logic [7:0] pay_r [MAX_PAYLOAD];
    logic [7:0] pay_nxt [MAX_PAYLOAD];
    logic [9:0] tx_sh_r, tx_sh_nxt;
    logic [3:0] tx_idx_r, tx_idx_nxt, id_nxt;
    logic stat_r, stat_nxt, tx_nxt, reg_wr_nxt, reg_rd_nxt, wdt_nxt, pwm_nxt, nv_top;
    logic receiving, is_bcast, crc_ok, id_match, load_stat;

    // Byte receiver
    logic rx_busy_r, rx_busy_nxt;
    logic [3:0] rx_idx_r, rx_idx_nxt;
    logic [PER_W-1:0] rx_cnt_r, rx_cnt_nxt;
    logic [7:0] rx_sh_r, rx_sh_nxt;
    logic rx_done, rx_err;

    always_comb begin
        rx_busy_nxt = rx_busy_r;
        rx_idx_nxt = rx_idx_r;
        rx_cnt_nxt = rx_cnt_r;
        rx_sh_nxt = rx_sh_r;
        rx_done = 1'b0;
        rx_err = 1'b0;
        if (!receiving || state_r == F_SYNC) begin
            rx_busy_nxt = 1'b0;
        end else if (!rx_busy_r) begin
            if (line_fall) begin
                // Half a period lands the samples at bit centres
                rx_busy_nxt = 1'b1;
                rx_idx_nxt = 4'h0;
                rx_cnt_nxt = bit_per_r >> 1;
            end
        end else if (rx_cnt_r != '0) begin
            rx_cnt_nxt = rx_cnt_r - 1'b1;
        end else begin
            rx_cnt_nxt = bit_per_r - 1'b1;
            rx_idx_nxt = rx_idx_r + 4'h1;
            if (rx_idx_r == 4'h0) begin
                // A high start sample was only a glitch
                rx_busy_nxt = ~rx_q2_r;
            end else if (rx_idx_r == RX_LAST_BIT) begin
                rx_busy_nxt = 1'b0;
                rx_done = rx_q2_r;
                rx_err = ~rx_q2_r;
            end else begin
                rx_sh_nxt = {rx_q2_r, rx_sh_r[7:1]};
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rx_busy_r <= 1'b0;
            rx_idx_r <= 4'h0;
            rx_cnt_r <= '0;
            rx_sh_r <= 8'h00;
        end else begin
            rx_busy_r <= rx_busy_nxt;
            rx_idx_r <= rx_idx_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            rx_sh_r <= rx_sh_nxt;
        end
    end

    // Frame decode, execution and response
    assign receiving = state_r inside {F_SYNC, F_TSEL, F_PTR, F_DATA, F_CRC};
    assign is_bcast = tsel_r[TS_BCAST];
    assign crc_upd = ufs_crc8(crc_r, rx_sh_r);
    assign crc_ok = (rx_sh_r == crc_r);
    assign last_idx = 3'((4'h1 << tsel_r[TS_LEN_LSB +: 2]) - 4'h1);
    assign nv_top = i_nv_valid ? i_nv_slave_identity[NV_TOP] : NV_ID_TOP_DEFAULT;
    // Broadcast needs both the frame and this slave at identity 0h
    assign id_match = is_bcast ? (o_slave_id == BCAST_ID && tsel_r[3:0] == BCAST_ID)
                               : (tsel_r[3:0] == o_slave_id);
    always_comb begin
        unique case (i_frame_gap_limit_cfg)
            2'h0: gap_lim = GAP_W'(P_GAP_CYC0);
            2'h1: gap_lim = GAP_W'(P_GAP_CYC1);
            2'h2: gap_lim = GAP_W'(P_GAP_CYC2);
            2'h3: gap_lim = GAP_W'(P_GAP_CYC3);
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        bit_per_nxt = bit_per_r;
        span_nxt = span_r;
        falls_nxt = falls_r;
        tsel_nxt = tsel_r;
        ptr_nxt = ptr_r;
        crc_nxt = crc_r;
        idx_nxt = idx_r;
        pay_nxt = pay_r;
        tx_sh_nxt = tx_sh_r;
        tx_idx_nxt = tx_idx_r;
        tx_cnt_nxt = tx_cnt_r;
        stat_nxt = stat_r;
        tx_nxt = 1'b1;
        reg_addr_nxt = o_reg_addr;
        reg_wdata_nxt = o_reg_wdata;
        reg_wr_nxt = 1'b0;
        reg_rd_nxt = 1'b0;
        wdt_nxt = 1'b0;
        load_stat = 1'b0;
        gap_nxt = (line_edge || !receiving) ? '0 : gap_r + 1'b1;
        unique case (state_r)
            F_HUNT: begin
                if (line_fall) begin
                    state_nxt = F_SYNC;
                    span_nxt = '0;
                    falls_nxt = 3'h0;
                end
            end
            F_SYNC: begin
                span_nxt = span_r + 1'b1;
                if (span_r > SPAN_MAX) begin
                    state_nxt = F_HUNT;
                end else if (line_fall) begin
                    falls_nxt = falls_r + 3'h1;
                    if (falls_nxt == SYNC_FALLS) begin
                        if (span_r < SPAN_MIN) begin
                            state_nxt = F_HUNT;
                        end else begin
                            bit_per_nxt = PER_W'((span_r + 1'b1) >> SYNC_SHIFT);
                            crc_nxt = CRC_SEED;
                            state_nxt = F_TSEL;
                        end
                    end
                end
            end
            F_TSEL: begin
                if (rx_done) begin
                    tsel_nxt = rx_sh_r;
                    crc_nxt = crc_upd;
                    state_nxt = F_PTR;
                end
            end
            F_PTR: begin
                if (rx_done) begin
                    ptr_nxt = rx_sh_r;
                    crc_nxt = crc_upd;
                    idx_nxt = 3'h0;
                    state_nxt = tsel_r[TS_WRITE] ? F_DATA : F_CRC;
                end
            end
            F_DATA: begin
                if (rx_done) begin
                    pay_nxt[idx_r] = rx_sh_r;
                    crc_nxt = crc_upd;
                    idx_nxt = idx_r + 3'h1;
                    if (idx_r == last_idx) begin
                        state_nxt = F_CRC;
                    end
                end
            end
            F_CRC: begin
                if (rx_done) begin
                    idx_nxt = 3'h0;
                    if (crc_ok && id_match) begin
                        state_nxt = F_EXEC;
                        wdt_nxt = 1'b1;
                    end else begin
                        state_nxt = F_HUNT;
                    end
                end
            end
            F_EXEC: begin
                reg_addr_nxt = ptr_r + 8'(idx_r);
                if (tsel_r[TS_WRITE]) begin
                    reg_wr_nxt = 1'b1;
                    reg_wdata_nxt = pay_r[idx_r];
                    idx_nxt = idx_r + 3'h1;
                    if (idx_r == last_idx) begin
                        state_nxt = F_HUNT;
                        load_stat = ~is_bcast;
                    end
                end else begin
                    reg_rd_nxt = 1'b1;
                    state_nxt = F_RDREQ;
                end
            end
            F_RDREQ: state_nxt = F_RDCAP;
            F_RDCAP: begin
                if (is_bcast) begin
                    // Reads still happen so read side effects match
                    idx_nxt = idx_r + 3'h1;
                    state_nxt = (idx_r == last_idx) ? F_HUNT : F_EXEC;
                end else begin
                    tx_sh_nxt = ufs_uart_frame(i_reg_rdata);
                    tx_idx_nxt = 4'h0;
                    tx_cnt_nxt = bit_per_r - 1'b1;
                    stat_nxt = 1'b0;
                    state_nxt = F_TX;
                end
            end
            F_TX: begin
                tx_nxt = tx_sh_r[0];
                if (tx_cnt_r != '0) begin
                    tx_cnt_nxt = tx_cnt_r - 1'b1;
                end else if (tx_idx_r != TX_LAST_BIT) begin
                    tx_sh_nxt = {1'b1, tx_sh_r[9:1]};
                    tx_idx_nxt = tx_idx_r + 4'h1;
                    tx_cnt_nxt = bit_per_r - 1'b1;
                end else if (stat_r) begin
                    state_nxt = F_HUNT;
                end else if (idx_r == last_idx) begin
                    load_stat = 1'b1;
                end else begin
                    idx_nxt = idx_r + 3'h1;
                    state_nxt = F_EXEC;
                end
            end
        endcase
        if (load_stat) begin
            tx_sh_nxt = ufs_uart_frame(i_primary_fault_summary);
            tx_idx_nxt = 4'h0;
            tx_cnt_nxt = bit_per_r - 1'b1;
            stat_nxt = 1'b1;
            state_nxt = F_TX;
        end
        // Silent line or broken stop bit drops the partial frame
        if (receiving && (gap_r >= gap_lim || rx_err)) begin
            state_nxt = F_HUNT;
        end
        if (i_nv_valid && i_nv_address_source_select) begin
            id_nxt = i_nv_slave_identity;
            pwm_nxt = 1'b1;
        end else begin
            id_nxt = {nv_top, pin_q2_r};
            pwm_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_r <= F_HUNT;
            bit_per_r <= PER_W'(BIT_CYC_MAX);
            span_r <= '0;
            falls_r <= 3'h0;
            gap_r <= '0;
            tsel_r <= 8'h00;
            ptr_r <= 8'h00;
            crc_r <= CRC_SEED;
            idx_r <= 3'h0;
            tx_sh_r <= 10'h3FF;
            tx_idx_r <= 4'h0;
            tx_cnt_r <= '0;
            stat_r <= 1'b0;
            o_tx <= 1'b1;
            o_reg_addr <= 8'h00;
            o_reg_wdata <= 8'h00;
            o_reg_wr <= 1'b0;
            o_reg_rd <= 1'b0;
            o_wdt_clear <= 1'b0;
            o_slave_id <= 4'h0;
            o_pins_as_pwm <= 1'b0;
        end else begin
            state_r <= state_nxt;
            bit_per_r <= bit_per_nxt;
            span_r <= span_nxt;
            falls_r <= falls_nxt;
            gap_r <= gap_nxt;
            tsel_r <= tsel_nxt;
            ptr_r <= ptr_nxt;
            crc_r <= crc_nxt;
            idx_r <= idx_nxt;
            tx_sh_r <= tx_sh_nxt;
            tx_idx_r <= tx_idx_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            stat_r <= stat_nxt;
            o_tx <= tx_nxt;
            o_reg_addr <= reg_addr_nxt;
            o_reg_wdata <= reg_wdata_nxt;
            o_reg_wr <= reg_wr_nxt;
            o_reg_rd <= reg_rd_nxt;
            o_wdt_clear <= wdt_nxt;
            o_slave_id <= id_nxt;
            o_pins_as_pwm <= pwm_nxt;
        end
    end
    // Payload is data only, so it carries no reset
    always_ff @(posedge i_clk) begin
        pay_r <= pay_nxt;
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_idle_line_high: assert property (
        ($past(state_r) != F_TX) |-> o_tx)
        else $error("line not idle high outside a reply");
    a_tx_lsb_first: assert property (
        (state_r == F_TX && tx_cnt_r == '0 && tx_idx_r != TX_LAST_BIT)
        |=> (tx_sh_r[0] == $past(tx_sh_r[1])) ##1 (o_tx == tx_sh_r[0]))
        else $error("reply bits not shifted out in ascending order");
    a_rate_lock_range: assert property (
        (state_r == F_TSEL) |-> (bit_per_r >= PER_LO && bit_per_r <= PER_HI))
        else $error("locked bit period outside supported rates");
    a_sync_before_bytes: assert property (
        (state_r == F_TSEL && $past(state_r) != F_TSEL) |-> ($past(state_r) == F_SYNC))
        else $error("byte reception began without a sync lock");
    a_wdt_after_crc: assert property (
        o_wdt_clear |-> ($past(rx_done) && $past(crc_ok) && $past(id_match)))
        else $error("watchdog cleared without a good addressed frame");
    a_gap_abandon: assert property (
        (receiving && gap_r >= gap_lim) |=> (state_r == F_HUNT))
        else $error("frame kept after the gap limit ran out");
    a_bad_crc_silent: assert property (
        (state_r == F_CRC && rx_done && !crc_ok)
        |=> (state_r == F_HUNT && !o_wdt_clear) ##1 o_tx[*2])
        else $error("bad CRC frame was answered");
    a_status_byte: assert property (
        load_stat |=> (state_r == F_TX && stat_r
            && tx_sh_r == ufs_uart_frame($past(i_primary_fault_summary))))
        else $error("status byte not loaded from fault summary");
    a_bcast_quiet: assert property (
        (is_bcast && state_r != F_HUNT) |-> (state_r != F_TX))
        else $error("reply sent for a broadcast frame");
    a_id_nv_source: assert property (
        (i_nv_valid && i_nv_address_source_select)
        |=> (o_slave_id == $past(i_nv_slave_identity) && o_pins_as_pwm))
        else $error("identity not taken from nonvolatile bits");
    a_id_pin_source: assert property (
        (i_nv_valid && !i_nv_address_source_select)
        |=> (o_slave_id == {$past(nv_top), $past(pin_q2_r)} && !o_pins_as_pwm))
        else $error("identity not formed from top bit and pins");
    a_id_top_default: assert property (
        !i_nv_valid |=> (o_slave_id[NV_TOP] == NV_ID_TOP_DEFAULT))
        else $error("top identity bit not at its default");
    c_write_reply: cover property (tsel_r[TS_WRITE] && load_stat);
    c_read_reply: cover property (state_r == F_RDCAP && !is_bcast);
    c_gap_abort: cover property (receiving && gap_r >= gap_lim);
    c_bcast_write: cover property (o_reg_wr && is_bcast);

endmodule

/* File: src/ufs_pkg.sv */
// Constants, types and helpers for the frame slave port
package ufs_pkg;

    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
    localparam int unsigned RATE_MIN_HZ = 10_000;
    localparam int unsigned RATE_MAX_HZ = 1_000_000;
    localparam int unsigned BIT_CYC_MIN = CLK_HZ / RATE_MAX_HZ;
    localparam int unsigned BIT_CYC_MAX = CLK_HZ / RATE_MIN_HZ;

    localparam int PER_W = 13;
    localparam int SPAN_W = 16;
    // Sync byte gives five falling edges eight bit times apart end to end
    localparam logic [2:0] SYNC_FALLS = 3'h4;
    localparam int SYNC_SHIFT = 3;
    localparam logic [SPAN_W-1:0] SPAN_MIN = SPAN_W'(7 * BIT_CYC_MIN);
    localparam logic [SPAN_W-1:0] SPAN_MAX = SPAN_W'(9 * BIT_CYC_MAX);

    // Gap limit choices, in microseconds
    localparam int unsigned GAP_T_US0 = 1000;
    localparam int unsigned GAP_T_US1 = 2000;
    localparam int unsigned GAP_T_US2 = 5000;
    localparam int unsigned GAP_T_US3 = 10000;
    localparam int unsigned GAP_CYC0 = GAP_T_US0 * CLK_MHZ;
    localparam int unsigned GAP_CYC1 = GAP_T_US1 * CLK_MHZ;
    localparam int unsigned GAP_CYC2 = GAP_T_US2 * CLK_MHZ;
    localparam int unsigned GAP_CYC3 = GAP_T_US3 * CLK_MHZ;
    localparam int GAP_W = 20;

    localparam logic [7:0] CRC_SEED = 8'hFF;
    localparam logic [7:0] CRC_POLY = 8'h07;

    localparam int TS_LEN_LSB = 4;
    localparam int TS_BCAST = 6;
    localparam int TS_WRITE = 7;
    localparam logic [3:0] BCAST_ID = 4'h0;
    localparam int NV_TOP = 3;
    localparam logic NV_ID_TOP_DEFAULT = 1'b0;

    localparam logic [3:0] RX_LAST_BIT = 4'h9;
    localparam logic [3:0] TX_LAST_BIT = 4'h9;
    localparam int MAX_PAYLOAD = 8;

    typedef enum logic [3:0] {
        F_HUNT, F_SYNC, F_TSEL, F_PTR, F_DATA, F_CRC, F_EXEC, F_RDREQ, F_RDCAP, F_TX
    } ufs_state_t;

    function automatic logic [7:0] ufs_crc8(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    // Stop bit, data LSB first, start bit
    function automatic logic [9:0] ufs_uart_frame(input logic [7:0] data);
        return {1'b1, data, 1'b0};
    endfunction

endpackage

/* File: tb/uart_frame_slave_port_tb.sv */
// Self-checking bench for the frame slave port
module uart_frame_slave_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk, i_rst, rx, tx, ph, pm, pl, nv_valid, nv_src, wr, rd, wdt, pwm;
    logic [3:0] nv_id, slave_id;
    logic [1:0] gap_cfg;
    logic [7:0] fault, addr, wdata, rdata;
    logic [7:0] d[8];
    logic [15:0] wq[$];
    logic [5:0] idt[3] = '{6'h35, 6'h2A, 6'h0A};
    logic [4:0] ide[3] = '{5'h15, 5'h0C, 5'h05};
    int n_errors = 0;
    int comparisons = 0;
    int n_wdt = 0;
    ufs_frame_slave_port #(.P_GAP_CYC0(2000), .P_GAP_CYC1(4000), .P_GAP_CYC2(8000),
                           .P_GAP_CYC3(16000)) i_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_rx(rx), .o_tx(tx),
        .i_identity_pin_high(ph), .i_identity_pin_mid(pm), .i_identity_pin_low(pl),
        .i_nv_valid(nv_valid), .i_nv_address_source_select(nv_src), .i_nv_slave_identity(nv_id),
        .i_frame_gap_limit_cfg(gap_cfg), .i_primary_fault_summary(fault), .o_reg_addr(addr),
        .o_reg_wdata(wdata), .o_reg_wr(wr), .o_reg_rd(rd), .i_reg_rdata(rdata),
        .o_wdt_clear(wdt), .o_slave_id(slave_id), .o_pins_as_pwm(pwm));
    ufs_master_model #(.BIT_CYC(40)) i_master (.i_clk(i_clk), .i_line(tx), .o_line(rx));
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    // Register file stand-in; junk outside the valid cycle
    always @(posedge i_clk) begin
        rdata <= rd ? (addr ^ 8'h3C) : ~rdata;
        if (wr) wq.push_back({addr, wdata});
        if (wdt) n_wdt++;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // nrep: data bytes before status, -1 for silence; wx -1 skips the watchdog check
    task automatic run_frame(input logic [7:0] ts, input logic [7:0] p, input logic bad,
                             input int gap, input int nrep, input int wx, input logic wre);
        logic [7:0] b;
        logic got;
        logic [7:0] e;
        int w0;
        w0 = n_wdt;
        // Listen while sending: the reply starts inside the last stop bit
        fork
            i_master.send_frame(ts, p, d, bad, gap);
            begin
                for (int i = 0; i <= nrep; i++) begin
                    i_master.recv_byte(b, got);
                    e = (i == nrep) ? fault : ((p + 8'(i)) ^ 8'h3C);
                    check({7'h0, got, b}, {8'h01, e});
                end
                if (nrep < 0) begin
                    i_master.recv_byte(b, got);
                    check(16'(got), 16'h0);
                end
            end
        join
        if (wx >= 0) begin
            check(16'(n_wdt - w0), 16'(wx));
        end
        check(16'(wq.size()), wre ? 16'(1 << ts[5:4]) : 16'h0);
        for (int i = 0; i < wq.size(); i++) begin
            check(wq[i], {p + 8'(i), d[i]});
        end
        wq.delete();
        repeat (100) @(posedge i_clk);
    endtask
    initial begin
        {i_rst, nv_valid, nv_src, ph, pm, pl} = 6'h3B;
        nv_id = 4'h5;
        gap_cfg = 2'h0;
        fault = 8'hA6;
        for (int i = 0; i < 8; i++) begin
            d[i] = 8'(8'h29 * i + 8'h07);
        end
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            {nv_valid, nv_src, nv_id} <= idt[k];
            {ph, pm, pl} <= 3'(k + 3);
            repeat (4) @(posedge i_clk);
            check(16'({pwm, slave_id}), 16'(ide[k]));
        end
        {nv_valid, nv_src, nv_id} <= 6'h35;
        repeat (4) @(posedge i_clk);
        for (int k = 0; k < 4; k++) begin
            run_frame(8'h85 | 8'(k << 4), 8'hFE, 1'b0, 0, 0, 1, 1'b1);
        end
        run_frame(8'h15, 8'h40, 1'b0, 0, 2, 1, 1'b0);
        fault <= 8'h5B;
        run_frame(8'h85, 8'h10, 1'b1, 0, -1, 0, 1'b0);
        run_frame(8'h86, 8'h10, 1'b0, 0, -1, 0, 1'b0);
        run_frame(8'hC0, 8'h10, 1'b0, 0, -1, 0, 1'b0);
        gap_cfg <= 2'h3;
        run_frame(8'h85, 8'h20, 1'b0, 3000, 0, 1, 1'b1);
        gap_cfg <= 2'h0;
        i_master.send_byte(8'h55);
        i_master.send_byte(8'h95);
        repeat (3000) @(posedge i_clk);
        run_frame(8'h95, 8'h24, 1'b0, 0, 0, 1, 1'b1);
        {nv_valid, nv_src, nv_id} <= 6'h30;
        repeat (4) @(posedge i_clk);
        run_frame(8'hD0, 8'h30, 1'b0, 0, -1, 1, 1'b1);
        run_frame(8'h50, 8'h30, 1'b0, 0, -1, 1, 1'b0);
        complete_run();
    end
    initial begin
        repeat (90000) @(posedge i_clk);
        n_errors++;
        complete_run();
    end
endmodule

/* File: tb/ufs_master_model.sv */
// Master side of the link: byte framing, frame building, reply capture
module ufs_master_model #(
    parameter int BIT_CYC = 40
) (
    input wire logic i_clk,
    input wire logic i_line,
    output logic o_line
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_line = 1'b1;
    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
        c = c ^ b;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
        end
        return c;
    endfunction
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            o_line <= f[i];
            repeat (BIT_CYC) @(posedge i_clk);
        end
    endtask
    // Gap after the select byte probes the gap limit; bad flips the CRC
    task automatic send_frame(input logic [7:0] ts, input logic [7:0] p, input logic [7:0] d[8],
                              input logic bad, input int gap);
        logic [7:0] c;
        int n;
        n = ts[7] ? (1 << ts[5:4]) : 0;
        send_byte(8'h55);
        send_byte(ts);
        repeat (gap) @(posedge i_clk);
        send_byte(p);
        c = crc_step(crc_step(8'hFF, ts), p);
        for (int i = 0; i < n; i++) begin
            send_byte(d[i]);
            c = crc_step(c, d[i]);
        end
        send_byte(bad ? ~c : c);
    endtask
    task automatic recv_byte(output logic [7:0] b, output logic got);
        int t;
        b = 8'h00;
        got = 1'b0;
        t = 0;
        while (i_line !== 1'b0 && t < 6000) begin
            @(posedge i_clk);
            t++;
        end
        if (i_line === 1'b0) begin
            repeat (BIT_CYC / 2) @(posedge i_clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(posedge i_clk);
                b[i] = i_line;
            end
            repeat (BIT_CYC) @(posedge i_clk);
            // Return at mid stop bit so a back-to-back byte is not missed
            got = (i_line === 1'b1);
        end
    endtask
endmodule
